// *** design/phy_access_pkg.sv ***
package phy_access_pkg;

   // software register byte offsets
   localparam logic [7:0] OFS_PHY_CTRL = 8'h00;
   localparam logic [7:0] OFS_NODE_ID = 8'h04;
   localparam logic [7:0] OFS_INT_EVENT = 8'h08;
   localparam logic [7:0] OFS_INT_MASK = 8'h0C;

   // device register indices, base and paged
   localparam logic [3:0] REG_NODE_SELF_STATUS = 4'h0;
   localparam logic [3:0] REG_RESET_AND_GAP_CTRL = 4'h1;
   localparam logic [3:0] REG_PORT_CAPABILITY = 4'h2;
   localparam logic [3:0] REG_SPEED_DELAY_INFO = 4'h3;
   localparam logic [3:0] REG_LINK_CONTENDER_POWER = 4'h4;
   localparam logic [3:0] REG_EVENT_AND_FEATURE_CTRL = 4'h5;
   localparam logic [3:0] REG_RESERVED_SIX = 4'h6;
   localparam logic [3:0] REG_PAGE_PORT_SELECTOR = 4'h7;
   localparam logic [3:0] REG_PAGED_FIRST = 4'h8;
   localparam logic [3:0] REG_PAGED_LAST = 4'hF;

   // interrupt event bit positions
   localparam int IRQ_PHY_REG_RECEIVED = 26;
   localparam int IRQ_BUS_RESET = 17;
   localparam logic [31:0] IRQ_IMPLEMENTED = 32'h0402_0000;

   // link request frame
   localparam logic [2:0] LREQ_READ_REG = 3'h4;
   localparam logic [2:0] LREQ_WRITE_REG = 3'h5;
   localparam int LREQ_FRAME_W = 17;
   localparam logic [4:0] LREQ_READ_LEN = 5'h09;
   localparam logic [4:0] LREQ_WRITE_LEN = 5'h11;

   // control line codes driven by the device
   localparam logic [1:0] CTL_IDLE = 2'h0;
   localparam logic [1:0] CTL_STATUS = 2'h1;

   // status transfer: two bits per cycle
   localparam logic [3:0] STAT_PAIRS_SHORT = 4'h2;
   localparam logic [3:0] STAT_PAIRS_FULL = 4'h8;
   localparam int STAT_BUS_RESET_BIT = 1;

   // reset values
   localparam logic [9:0] BUS_SEGMENT_ALL_ONES = 10'h3FF;
   localparam logic [5:0] NODE_INDEX_UNSET = 6'h3F;

   typedef struct packed {
      logic read_complete_flag;
      logic [2:0] rsvd_hi;
      logic [3:0] returned_reg_index;
      logic [7:0] returned_reg_value;
      logic read_request_bit;
      logic write_request_bit;
      logic [1:0] rsvd_lo;
      logic [3:0] target_reg_index;
      logic [7:0] write_value;
   } phy_ctrl_t;

   typedef struct packed {
      logic node_number_valid;
      logic root_status;
      logic [1:0] rsvd_a;
      logic cable_power_ok;
      logic [10:0] rsvd_b;
      logic [9:0] bus_segment_index;
      logic [5:0] local_node_index;
   } node_id_t;

   localparam phy_ctrl_t PHY_CTRL_RESET = 32'h0000_0000;

endpackage

// *** design/pin_sync3.sv ***
`timescale 1ns/100ps
// three-stage synchroniser; the held value follows once stages two and three agree
module pin_sync3 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pins in, stable value out
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] stable_out
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // stage one feeds stage two only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a glitch that lasts a single cycle never reaches the output
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stable_out <= '0;
      end else if (s2_r == s3_r) begin
         stable_out <= s3_r;
      end
   end
endmodule

// *** design/lreq_serializer.sv ***
`timescale 1ns/100ps
// shifts one link request frame out, first bit first, one bit per clock
module lreq_serializer (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // frame in
   input wire logic start,
   input wire logic [phy_access_pkg::LREQ_FRAME_W-1:0] frame,
   input wire logic [4:0] frame_len,
   // status
   output logic busy,
   output logic done,
   // pin
   output logic lreq
);
   logic [phy_access_pkg::LREQ_FRAME_W-1:0] sh_r;
   logic [4:0] cnt_r;

   // shifter and bit counter; an idle shifter holds zero so the pin rests low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sh_r <= '0;
         cnt_r <= 5'h00;
      end else if (start && cnt_r == 5'h00) begin
         sh_r <= frame;
         cnt_r <= frame_len;
      end else if (cnt_r != 5'h00) begin
         sh_r <= {sh_r[phy_access_pkg::LREQ_FRAME_W-2:0], 1'b0};
         cnt_r <= cnt_r - 5'h01;
      end
   end

   assign busy = (cnt_r != 5'h00);
   assign done = (cnt_r == 5'h01);
   assign lreq = sh_r[phy_access_pkg::LREQ_FRAME_W-1];
endmodule

// *** design/phy_register_access_port.sv ***
`timescale 1ns/100ps
module phy_register_access_port (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // software register port
   input wire logic [7:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [31:0] sw_rdata,
   // interrupt and dma gate
   output logic irq,
   output logic dma_run_permit,
   // device link pins
   output logic phy_lreq,
   input wire logic [1:0] phy_ctl_in,
   input wire logic [1:0] phy_data_in
);
   typedef enum {RX_IDLE, RX_STATUS} rx_state_t;

   phy_access_pkg::phy_ctrl_t ctrl_r;
   phy_access_pkg::node_id_t node_r;
   logic [31:0] int_event_r;
   logic [31:0] int_mask_r;
   logic [31:0] rdata_r;
   rx_state_t rx_state_r;
   logic [15:0] stat_sh_r;
   logic [3:0] stat_pairs_r;
   logic [1:0] ctl_s;
   logic [1:0] data_s;
   logic [1:0] data_p1_r;
   logic [1:0] data_p2_r;
   logic [1:0] data_p3_r;
   logic [1:0] data_p4_r;
   logic ser_busy;
   logic ser_done;
   logic ser_start;
   logic [phy_access_pkg::LREQ_FRAME_W-1:0] ser_frame;
   logic [4:0] ser_len;
   logic wr_ctrl;
   logic req_accept;
   logic reg_rcv;
   logic bus_reset_seen;
   logic [3:0] stat_bits;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and request shifter

   pin_sync3 #(.W(2)) u_sync (
      .clk(clk),
      .rst(rst),
      .pin_in(phy_ctl_in),
      .stable_out(ctl_s)
   );

   // data lanes carry a new pair every clock, so they cannot wait for two stages to agree;
   // the fourth stage matches the filter's output register and keeps data in step with ctl
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_p1_r <= 2'h0;
         data_p2_r <= 2'h0;
         data_p3_r <= 2'h0;
         data_p4_r <= 2'h0;
      end else begin
         data_p1_r <= phy_data_in;
         data_p2_r <= data_p1_r;
         data_p3_r <= data_p2_r;
         data_p4_r <= data_p3_r;
      end
   end

   assign data_s = data_p4_r;

   lreq_serializer u_lreq (
      .clk(clk),
      .rst(rst),
      .start(ser_start),
      .frame(ser_frame),
      .frame_len(ser_len),
      .busy(ser_busy),
      .done(ser_done),
      .lreq(phy_lreq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // software access decode

   // a decode used by several processes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   assign wr_ctrl = sw_wr && hit(sw_addr, phy_access_pkg::OFS_PHY_CTRL);
   assign req_accept = wr_ctrl && (sw_wdata[15] ^ sw_wdata[14]) &&
                       !ctrl_r.read_request_bit && !ctrl_r.write_request_bit;

   ////////////////////////////////////////////////////////////////////////////
   // link request launch

   // frame format: start bit, type, index, data (write frames only), stop bit
   always_comb begin
      ser_start = (ctrl_r.read_request_bit || ctrl_r.write_request_bit) && !ser_busy;
      if (ctrl_r.write_request_bit) begin
         ser_frame = {1'b1, phy_access_pkg::LREQ_WRITE_REG, ctrl_r.target_reg_index,
                      ctrl_r.write_value, 1'b0};
         ser_len = phy_access_pkg::LREQ_WRITE_LEN;
      end else begin
         ser_frame = {1'b1, phy_access_pkg::LREQ_READ_REG, ctrl_r.target_reg_index,
                      1'b0, 8'h00};
         ser_len = phy_access_pkg::LREQ_READ_LEN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status transfer receiver

   // device shifts status two bits per cycle while ctl shows status
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_state_r <= RX_IDLE;
         stat_sh_r <= 16'h0000;
         stat_pairs_r <= 4'h0;
      end else begin
         case (rx_state_r)
            RX_IDLE: begin
               if (ctl_s == phy_access_pkg::CTL_STATUS) begin
                  rx_state_r <= RX_STATUS;
                  stat_sh_r <= {14'h0000, data_s[0], data_s[1]};
                  stat_pairs_r <= 4'h1;
               end
            end
            RX_STATUS: begin
               if (ctl_s == phy_access_pkg::CTL_STATUS) begin
                  stat_sh_r <= {stat_sh_r[13:0], data_s[0], data_s[1]};
                  if (stat_pairs_r != 4'hF) begin
                     stat_pairs_r <= stat_pairs_r + 4'h1;
                  end
               end else begin
                  rx_state_r <= RX_IDLE;
               end
            end
            default: begin
               rx_state_r <= RX_IDLE;
            end
         endcase
      end
   end

   // end of transfer: short carries status only, full adds index and value
   always_comb begin
      reg_rcv = 1'b0;
      stat_bits = 4'h0;
      if (rx_state_r == RX_STATUS && ctl_s != phy_access_pkg::CTL_STATUS) begin
         if (stat_pairs_r == phy_access_pkg::STAT_PAIRS_FULL) begin
            reg_rcv = 1'b1;
            stat_bits = stat_sh_r[15:12];
         end else if (stat_pairs_r == phy_access_pkg::STAT_PAIRS_SHORT) begin
            stat_bits = stat_sh_r[3:0];
         end
      end
      // the third bit sent lands at position one of the four status bits
      bus_reset_seen = stat_bits[phy_access_pkg::STAT_BUS_RESET_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////
   // access control register

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= phy_access_pkg::PHY_CTRL_RESET;
      end else begin
         if (wr_ctrl && !ctrl_r.read_request_bit && !ctrl_r.write_request_bit) begin
            ctrl_r.target_reg_index <= sw_wdata[11:8];
            ctrl_r.write_value <= sw_wdata[7:0];
         end
         if (req_accept) begin
            ctrl_r.read_request_bit <= sw_wdata[15];
            ctrl_r.write_request_bit <= sw_wdata[14];
            // flag cleared by a new request
            ctrl_r.read_complete_flag <= 1'b0;
         end else if (ser_done) begin
            ctrl_r.read_request_bit <= 1'b0;
            ctrl_r.write_request_bit <= 1'b0;
         end
         if (reg_rcv) begin
            // completion flag, set wins over a same-cycle clear
            ctrl_r.read_complete_flag <= 1'b1;
            ctrl_r.returned_reg_index <= stat_sh_r[11:8];
            ctrl_r.returned_reg_value <= stat_sh_r[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // node identity mirror

   // base register zero reaches software through this mirror and through the returned fields of the control register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         node_r <= '0;
         node_r.bus_segment_index <= phy_access_pkg::BUS_SEGMENT_ALL_ONES;
         node_r.local_node_index <= phy_access_pkg::NODE_INDEX_UNSET;
      end else begin
         if (sw_wr && hit(sw_addr, phy_access_pkg::OFS_NODE_ID)) begin
            node_r.bus_segment_index <= sw_wdata[15:6];
         end
         if (reg_rcv && stat_sh_r[11:8] == phy_access_pkg::REG_NODE_SELF_STATUS) begin
            node_r.local_node_index <= stat_sh_r[7:2];
            node_r.root_status <= stat_sh_r[1];
            node_r.cable_power_ok <= stat_sh_r[0];
            node_r.node_number_valid <= 1'b1;
         end else if (bus_reset_seen) begin
            node_r.node_number_valid <= 1'b0;
         end
         if (bus_reset_seen) begin
            node_r.bus_segment_index <= phy_access_pkg::BUS_SEGMENT_ALL_ONES;
         end
      end
   end

   assign dma_run_permit = node_r.node_number_valid &&
                           (node_r.local_node_index != phy_access_pkg::NODE_INDEX_UNSET);

   ////////////////////////////////////////////////////////////////////////////
   // interrupt event and mask

   // write one clears; a new event in the same cycle wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_event_r <= 32'h0000_0000;
      end else begin
         int_event_r <= (int_event_r &
                         ~((sw_wr && hit(sw_addr, phy_access_pkg::OFS_INT_EVENT)) ?
                           sw_wdata : 32'h0000_0000)) |
                        ({31'h0000_0000, reg_rcv} << phy_access_pkg::IRQ_PHY_REG_RECEIVED) |
                        ({31'h0000_0000, bus_reset_seen} << phy_access_pkg::IRQ_BUS_RESET);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_mask_r <= 32'h0000_0000;
      end else if (sw_wr && hit(sw_addr, phy_access_pkg::OFS_INT_MASK)) begin
         int_mask_r <= sw_wdata & phy_access_pkg::IRQ_IMPLEMENTED;
      end
   end

   assign irq = |(int_event_r & int_mask_r);

   ////////////////////////////////////////////////////////////////////////////
   // read data, valid only in the cycle after the strobe

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (sw_rd) begin
         case (sw_addr)
            phy_access_pkg::OFS_PHY_CTRL: rdata_r <= ctrl_r;
            phy_access_pkg::OFS_NODE_ID: rdata_r <= node_r;
            phy_access_pkg::OFS_INT_EVENT: rdata_r <= int_event_r;
            phy_access_pkg::OFS_INT_MASK: rdata_r <= int_mask_r;
            default: rdata_r <= 32'h0000_0000;
         endcase
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end

   assign sw_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_lreq_quiet: assert property (!ser_busy |-> !phy_lreq)
      else $error("lreq high with no frame in flight");
   chk_start_bit: assert property ($rose(ser_busy) |-> phy_lreq)
      else $error("frame did not open with a start bit");
   chk_read_clear: assert property (ser_done && ctrl_r.read_request_bit && !req_accept
                                    |=> !ctrl_r.read_request_bit)
      else $error("read request bit not cleared after send");
   chk_read_len: assert property ($rose(ser_busy) && ctrl_r.read_request_bit
                                  |-> ser_busy [*8] ##1 ser_done ##1 !ser_busy)
      else $error("read frame length wrong");
   chk_write_clear: assert property ($rose(ser_busy) && ctrl_r.write_request_bit
                                     |-> ##16 ser_done ##1 !ctrl_r.write_request_bit)
      else $error("write request bit not cleared after send");
   chk_done_set: assert property (reg_rcv |=> ctrl_r.read_complete_flag &&
                                  int_event_r[phy_access_pkg::IRQ_PHY_REG_RECEIVED])
      else $error("register receipt not flagged");
   chk_index_store: assert property (reg_rcv |=> ctrl_r.returned_reg_index ==
                                     $past(stat_sh_r[11:8]) &&
                                     ctrl_r.returned_reg_value == $past(stat_sh_r[7:0]))
      else $error("returned register not stored");
   chk_done_clear: assert property (req_accept && !reg_rcv |=> !ctrl_r.read_complete_flag)
      else $error("completion flag survived a new request");
   chk_excl_req: assert property (!(ctrl_r.read_request_bit && ctrl_r.write_request_bit))
      else $error("both request bits pending");
   chk_bus_reset: assert property (bus_reset_seen && !reg_rcv |=> !node_r.node_number_valid &&
                                   node_r.bus_segment_index == 10'h3FF)
      else $error("bus reset did not clear identity");
   chk_reset_event: assert property (bus_reset_seen |=>
                                     int_event_r[phy_access_pkg::IRQ_BUS_RESET])
      else $error("bus reset event not raised");
   chk_node_load: assert property (reg_rcv && stat_sh_r[11:8] == 4'h0 |=>
                                   node_r.node_number_valid && node_r.local_node_index ==
                                   $past(stat_sh_r[7:2]))
      else $error("node index not loaded");
   chk_dma_gate: assert property (node_r.local_node_index == 6'h3F |-> !dma_run_permit)
      else $error("dma permitted with unassigned node");

   cov_read_done: cover property (ctrl_r.read_request_bit ##[1:200] reg_rcv);
   cov_write_sent: cover property ($rose(ctrl_r.write_request_bit) ##[1:40]
                                   $fell(ctrl_r.write_request_bit));
   cov_bus_reset: cover property (bus_reset_seen);
   cov_irq: cover property ($rose(irq));
endmodule

// *** verification/phy_link_model.sv ***
`timescale 1ns/100ps
// behavioural device: decodes link requests, keeps base and paged registers, answers reads
module phy_link_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // answer pacing, cycles between request and answer
   input wire logic [3:0] resp_delay,
   // link pins
   input wire logic phy_lreq,
   output logic [1:0] phy_ctl,
   output logic [1:0] phy_data
);
   logic [7:0] base [8];
   logic [7:0] paged [64];
   logic [15:0] sh;
   int i;

   initial begin
      base = '{8'h00, 8'h3F, 8'hEC, 8'h40, 8'h80, 8'h00, 8'h00, 8'h00};
      for (i = 0; i < 64; i++) begin
         paged[i] = 8'h00;
      end
      phy_ctl = phy_access_pkg::CTL_IDLE;
      phy_data = 2'h1;
   end

   //////////////////////////////////////////////////////////////////////////////
   // status transfer, first bit on lane 0
   task automatic xfer(input logic [15:0] w, input int pairs);
      for (int p = 0; p < pairs; p++) begin
         @(posedge clk);
         phy_ctl <= phy_access_pkg::CTL_STATUS;
         phy_data <= {w[14 - 2 * p], w[15 - 2 * p]};
      end
      @(posedge clk);
      phy_ctl <= phy_access_pkg::CTL_IDLE;
      // released lanes hold the inverse of the last pair, so stale data never looks valid
      phy_data <= ~phy_data;
   endtask

   //////////////////////////////////////////////////////////////////////////////
   // request frame decode
   always begin
      @(posedge clk);
      if (!rst && phy_lreq === 1'b1) begin
         for (i = 0; i < 7; i++) begin
            @(posedge clk);
            sh = {sh[14:0], phy_lreq};
         end
         if (sh[6:4] == phy_access_pkg::LREQ_WRITE_REG) begin
            for (i = 0; i < 8; i++) begin
               @(posedge clk);
               sh = {sh[14:0], phy_lreq};
            end
            @(posedge clk);
            // upper indices reach the selected page
            if (sh[11])
               paged[{base[7][7:5], sh[10:8]}] = sh[7:0];
            // read-only and reserved places keep their value
            else if (sh[10:8] == 3'h4)
               base[4] = (base[4] & 8'h38) | (sh[7:0] & 8'hC7);
            else if (sh[10:8] == 3'h1 || sh[10:8] == 3'h5 || sh[10:8] == 3'h7)
               base[sh[10:8]] = sh[7:0];
         end else begin
            @(posedge clk);
            repeat (resp_delay) @(posedge clk);
            xfer({4'h0, sh[3:0], sh[3] ? paged[{base[7][7:5], sh[2:0]}] : base[sh[2:0]]}, 8);
         end
      end
   end
endmodule

// *** verification/phy_register_access_port_bench.sv ***
`timescale 1ns/100ps
// register-port bench for the device register access path
module phy_register_access_port_bench;
   logic clk;
   logic rst;
   logic [7:0] sw_addr;
   logic [31:0] sw_wdata;
   logic sw_wr;
   logic sw_rd;
   logic [31:0] sw_rdata;
   logic irq;
   logic dma_run_permit;
   logic phy_lreq;
   logic [1:0] phy_ctl;
   logic [1:0] phy_data;
   logic [3:0] resp_delay;
   logic [31:0] rd;
   logic [7:0] v;
   int miscompares;
   int checks;

   always #20 clk = ~clk;

   phy_register_access_port u_phy_register_access_port (.clk(clk), .rst(rst),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata), .irq(irq), .dma_run_permit(dma_run_permit),
      .phy_lreq(phy_lreq), .phy_ctl_in(phy_ctl), .phy_data_in(phy_data));
   phy_link_model u_phy_link_model (.clk(clk), .rst(rst), .resp_delay(resp_delay),
      .phy_lreq(phy_lreq), .phy_ctl(phy_ctl), .phy_data(phy_data));

   //////////////////////////////////////////////////////////////////////////////
   // comparisons and verdict
   task chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task chk1(input logic got, input logic exp, input string what);
      chk32({31'h0, got}, {31'h0, exp}, what);
   endtask
   task tally_and_finish;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////////////
   // software port cycles
   task sw_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask
   task sw_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask
   // bounded poll until one bit reaches a value; rd keeps the last word
   task poll(input logic [7:0] a, input int b, input logic val);
      for (int n = 0; n < 100; n++) begin
         sw_read(a, rd);
         if (rd[b] === val)
            return;
      end
      miscompares++;
      $display("[ERR] %0t poll timed out", $time);
      tally_and_finish();
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      $display("[ERR] %0t run timed out", $time);
      tally_and_finish();
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      sw_addr = 8'h00;
      sw_wdata = 32'h0;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      resp_delay = 4'h0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      sw_read(phy_access_pkg::OFS_PHY_CTRL, rd);
      chk32(rd, 32'h0, "ctrl reset");
      sw_read(phy_access_pkg::OFS_NODE_ID, rd);
      chk32(rd, 32'h0000_FFFF, "node id reset");
      chk1(dma_run_permit, 1'b0, "dma gate reset");
      sw_read(8'h10, rd);
      chk32(rd, 32'h0, "unmapped read");
      // self identification delivers node 5, root, cable power good
      u_phy_link_model.xfer(16'h0017, 8);
      poll(phy_access_pkg::OFS_NODE_ID, 31, 1'b1);
      chk32(rd, 32'hC800_FFC5, "node id loaded");
      chk1(dma_run_permit, 1'b1, "dma gate open");
      sw_read(phy_access_pkg::OFS_PHY_CTRL, rd);
      chk32(rd, 32'h8017_0000, "register zero received");
      sw_read(phy_access_pkg::OFS_INT_EVENT, rd);
      chk32(rd, 32'h0400_0000, "received event");
      chk1(irq, 1'b0, "masked irq");
      sw_write(phy_access_pkg::OFS_INT_MASK, 32'hFFFF_FFFF);
      sw_read(phy_access_pkg::OFS_INT_MASK, rd);
      chk32(rd, 32'h0402_0000, "mask bits");
      chk1(irq, 1'b1, "irq raised");
      sw_write(phy_access_pkg::OFS_INT_EVENT, 32'h0400_0000);
      sw_read(phy_access_pkg::OFS_INT_EVENT, rd);
      chk32(rd, 32'h0, "event cleared");
      chk1(irq, 1'b0, "irq dropped");
      // write a base register, with a read refused while it is pending
      sw_write(phy_access_pkg::OFS_PHY_CTRL, 32'h0000_41A5);
      sw_read(phy_access_pkg::OFS_PHY_CTRL, rd);
      chk32(rd, 32'h0017_41A5, "write pending, flag cleared");
      sw_write(phy_access_pkg::OFS_PHY_CTRL, 32'h0000_8200);
      poll(phy_access_pkg::OFS_PHY_CTRL, 14, 1'b0);
      chk32(rd, 32'h0017_01A5, "refused read left no trace");
      chk32({24'h0, u_phy_link_model.base[1]}, 32'h0000_00A5, "device written");
      sw_write(phy_access_pkg::OFS_PHY_CTRL, 32'h0000_C300);
      sw_read(phy_access_pkg::OFS_PHY_CTRL, rd);
      chk32({30'h0, rd[15:14]}, 32'h0, "both bits refused");
      // select page one and write its second register
      sw_write(phy_access_pkg::OFS_PHY_CTRL, 32'h0000_4720);
      poll(phy_access_pkg::OFS_PHY_CTRL, 14, 1'b0);
      sw_write(phy_access_pkg::OFS_PHY_CTRL, 32'h0000_495A);
      poll(phy_access_pkg::OFS_PHY_CTRL, 14, 1'b0);
      // read every base index but zero and two paged ones, prompt and slow answers
      for (int k = 1; k < 10; k++) begin
         resp_delay <= k[0] ? 4'h7 : 4'h0;
         v = (k < 8) ? u_phy_link_model.base[k] : u_phy_link_model.paged[{3'h1, k[2:0]}];
         sw_write(phy_access_pkg::OFS_PHY_CTRL, {16'h0, 4'h8, k[3:0], 8'h00});
         poll(phy_access_pkg::OFS_PHY_CTRL, 31, 1'b1);
         chk32(rd, {4'h8, k[3:0], v, 4'h0, k[3:0], 8'h00}, "read returned");
      end
      // bus reset restores the segment and drops validity
      sw_write(phy_access_pkg::OFS_NODE_ID, 32'hFFFF_0000);
      sw_read(phy_access_pkg::OFS_NODE_ID, rd);
      chk32(rd, 32'hC800_0005, "segment written");
      sw_write(phy_access_pkg::OFS_INT_MASK, 32'h0002_0000);
      u_phy_link_model.xfer(16'h2000, 2);
      poll(phy_access_pkg::OFS_NODE_ID, 31, 1'b0);
      chk32({21'h0, rd[31], rd[15:6]}, 32'h0000_03FF, "bus reset state");
      chk1(dma_run_permit, 1'b0, "dma gate shut");
      chk1(irq, 1'b1, "bus reset irq");
      sw_read(phy_access_pkg::OFS_INT_EVENT, rd);
      chk32(rd, 32'h0402_0000, "events pending");
      // node number 63 keeps dma shut though valid
      u_phy_link_model.xfer(16'h00FC, 8);
      poll(phy_access_pkg::OFS_NODE_ID, 31, 1'b1);
      chk32({26'h0, rd[5:0]}, 32'h0000_003F, "node 63");
      chk1(dma_run_permit, 1'b0, "dma gate node 63");
      tally_and_finish();
   end
endmodule
